// ==== hw/ddr_port_pkg.sv ====
`default_nettype none
package ddr_port_pkg;
  // Organisation: four 9-bit lanes, nibbles on the 8-bit build
  localparam int DATA_W  = 36;
  localparam int LANE_W  = 9;
  localparam int LANES   = 4;
  localparam int NIB_W   = 4;
  localparam int NIBS    = 2;
  localparam int ADDR_W  = 18;
  // Reset values of the echo pins
  localparam logic ECHO_RST   = 1'h0;
  localparam logic ECHO_N_RST = 1'h1;

  // Every pin-side input, carried through the synchroniser together
  typedef struct packed {
    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic              load_n;
    logic              rnw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic [LANES-1:0]  lane_mask_n;
    logic [NIBS-1:0]   nib_mask_n;
  } pins_t;

  // Two words of one read burst, in delivery order
  typedef struct packed {
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
  } burst_t;

  // Read output sequencer
  typedef enum logic [1:0] {
    RD_IDLE,
    RD_SECOND,
    RD_HOLD
  } rd_state_t;
endpackage : ddr_port_pkg
`default_nettype wire

// ==== hw/ddr_burst2_sram_port.sv ====
// Behaviour
// - Write words are taken at the positive then negative input clock rise.
// - Data bus is driven only while read data is out, aligned to output clocks.
// - With both output clocks held high, input clocks time reads and echoes.
// - Without a new read, the bus floats once the current burst ends.
// - Active-low lane masks are sampled with the word they qualify.
// - A masked lane keeps its stored bits; the incoming bits are dropped.
// - Mask n covers data bits 9n+8 down to 9n.
// - The 8-bit build uses two active-low nibble masks instead.
// - Address is captured at the positive input clock rise of a command.
// - Lowest address bit picks the starting word when WORD_SELECT is set.
// - Load low at a positive input clock rise starts a two-word burst.
// - Load high starts nothing and ignores read-not-write.
// - Read-not-write high asks a read, low asks a write.
// - Echo clocks toggle always, rising with read data.
// - Bursts wrap within their two-word location.
// - Positive output rise raises true echo and drops complementary echo.
`default_nettype none
module ddr_burst2_sram_port
  import ddr_port_pkg::*;
#(
  parameter int AW          = ddr_port_pkg::ADDR_W,
  parameter bit NIBBLE_MODE = 1'b0,
  parameter bit WORD_SELECT = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                           CLK_I,
  input  wire logic                           SYS_RST_I,
  input  wire logic                           CE_I,
  // Input and output clock pairs
  input  wire logic                           K_I,
  input  wire logic                           K_N_I,
  input  wire logic                           C_I,
  input  wire logic                           C_N_I,
  // Command and address
  input  wire logic                           LOAD_N_I,
  input  wire logic                           RNW_I,
  input  wire logic [AW-1:0]                  WORD_ADDRESS_I,
  // Write masks
  input  wire logic [ddr_port_pkg::LANES-1:0] LANE_WRITE_MASK_N_I,
  input  wire logic [ddr_port_pkg::NIBS-1:0]  NIBBLE_WRITE_MASK_N_I,
  // Two-way data bus
  input  wire logic [ddr_port_pkg::DATA_W-1:0] DQ_I,
  output logic      [ddr_port_pkg::DATA_W-1:0] DQ_O,
  output logic                                 DQ_OE_O,
  // Echo timing pair
  output logic                                 ECHO_TIMING_PAIR_O,
  output logic                                 ECHO_TIMING_PAIR_N_O
);
  import ddr_port_pkg::*;

  pins_t             raw;
  pins_t             sync1;
  pins_t             pins;
  logic [3:0]        clk_prev;
  logic              k_rise;
  logic              kn_rise;
  logic              single;
  logic              pos_out;
  logic              neg_out;

  logic [DATA_W-1:0] mem [0:(2**AW)-1];
  logic              mem_we;
  logic [AW-1:0]     mem_waddr;
  logic [DATA_W-1:0] bit_en;
  logic [DATA_W-1:0] mem_wdata;

  logic              wr_armed;
  logic [AW-1:0]     wr_addr;
  logic              wr_second;
  logic [AW-1:0]     cur_addr;
  logic              next_wr_armed;
  logic [AW-1:0]     next_wr_addr;
  logic              next_wr_second;
  logic [AW-1:0]     next_cur_addr;

  logic              rd_pend;
  burst_t            rd_burst;
  logic [DATA_W-1:0] rd_hold;
  rd_state_t         rd_state;
  logic              next_rd_pend;
  burst_t            next_rd_burst;
  logic [DATA_W-1:0] next_rd_hold;
  rd_state_t         next_rd_state;
  logic [DATA_W-1:0] next_dq;
  logic              next_oe;
  logic              next_echo;
  logic              cmd_go;
  logic [AW-1:0]     cmd_a0;

  // All pins pass two flops; the bundle stays aligned, the link is far slower
  // Narrow builds zero-extend the address into the full-width bundle field
  assign raw = '{k: K_I, k_n: K_N_I, c: C_I, c_n: C_N_I, load_n: LOAD_N_I,
                 rnw: RNW_I, addr: ADDR_W'(WORD_ADDRESS_I), dq: DQ_I,
                 lane_mask_n: LANE_WRITE_MASK_N_I,
                 nib_mask_n: NIBBLE_WRITE_MASK_N_I};

  // Ones at reset so a clock pin held high shows no false rise; only stage two reads stage one
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sync1    <= '1;
      pins     <= '1;
      clk_prev <= 4'hF;
    end else if (CE_I) begin
      sync1    <= raw;
      pins     <= sync1;
      clk_prev <= {pins.k, pins.k_n, pins.c, pins.c_n};
    end
  end

  // Edge detection on the synchronised clock levels
  assign k_rise  = pins.k & ~clk_prev[3];
  assign kn_rise = pins.k_n & ~clk_prev[2];
  assign single  = pins.c & pins.c_n;
  assign pos_out = single ? k_rise : (pins.c & ~clk_prev[1]);
  assign neg_out = single ? kn_rise : (pins.c_n & ~clk_prev[0]);
  assign cmd_go  = k_rise & ~pins.load_n;
  assign cmd_a0  = WORD_SELECT ? pins.addr[AW-1:0] : {pins.addr[AW-1:1], 1'b0};

  // Per-bit write enables from lane or nibble masks
  for (genvar b = 0; b < DATA_W; b++) begin : g_bit_en
    if (NIBBLE_MODE) begin : g_nib
      if (b < NIB_W * NIBS) begin : g_on
        assign bit_en[b] = ~pins.nib_mask_n[b / NIB_W];
      end else begin : g_off
        assign bit_en[b] = 1'b0;
      end
    end else begin : g_lane
      assign bit_en[b] = ~pins.lane_mask_n[b / LANE_W];
    end
  end

  // Write sequencer: arm at command, first word next K rise, second at K_N
  always_comb begin
    next_wr_armed  = wr_armed;
    next_wr_addr   = wr_addr;
    next_wr_second = wr_second;
    next_cur_addr  = cur_addr;
    mem_we         = 1'b0;
    mem_waddr      = cur_addr;
    if (k_rise) begin
      next_wr_armed = 1'b0;
      if (wr_armed) begin
        mem_we         = 1'b1;
        mem_waddr      = wr_addr;
        next_cur_addr  = wr_addr;
        next_wr_second = 1'b1;
      end
      if (cmd_go && !pins.rnw) begin
        next_wr_armed = 1'b1;
        next_wr_addr  = cmd_a0;
      end
    end else if (kn_rise && wr_second) begin
      mem_we         = 1'b1;
      mem_waddr      = {cur_addr[AW-1:1], ~cur_addr[0]};
      next_wr_second = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      wr_armed  <= 1'b0;
      wr_addr   <= '0;
      wr_second <= 1'b0;
      cur_addr  <= '0;
    end else if (CE_I) begin
      wr_armed  <= next_wr_armed;
      wr_addr   <= next_wr_addr;
      wr_second <= next_wr_second;
      cur_addr  <= next_cur_addr;
    end
  end

  assign mem_wdata = (pins.dq & bit_en) | (mem[mem_waddr] & ~bit_en);

  // Storage has no reset, like the array it stands for
  always_ff @(posedge CLK_I) begin
    if (CE_I && mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // Read sequencer; reads see memory as of the command edge only
  // A write still in flight to the same pair is not forwarded to the read
  always_comb begin
    next_rd_pend  = rd_pend;
    next_rd_burst = rd_burst;
    next_rd_hold  = rd_hold;
    next_rd_state = rd_state;
    next_dq       = DQ_O;
    next_oe       = DQ_OE_O;
    next_echo     = ECHO_TIMING_PAIR_O;
    if (pos_out) begin
      next_echo    = 1'b1;
      next_rd_pend = 1'b0;
      if (rd_pend) begin
        next_dq       = rd_burst.w0;
        next_oe       = 1'b1;
        next_rd_hold  = rd_burst.w1;
        next_rd_state = RD_SECOND;
      end else begin
        next_oe       = 1'b0;
        next_rd_state = RD_IDLE;
      end
    end else if (neg_out) begin
      next_echo = 1'b0;
      case (rd_state)
        RD_SECOND: begin
          next_dq       = rd_hold;
          next_rd_state = RD_HOLD;
        end
        RD_IDLE, RD_HOLD: next_rd_state = rd_state;
        default:          next_rd_state = RD_IDLE;
      endcase
    end
    // back to back; a new read outranks the clear above
    if (cmd_go && pins.rnw) begin
      next_rd_pend     = 1'b1;
      next_rd_burst.w0 = mem[cmd_a0];
      next_rd_burst.w1 = mem[{cmd_a0[AW-1:1], ~cmd_a0[0]}];
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rd_pend              <= 1'b0;
      rd_burst             <= '0;
      rd_hold              <= '0;
      rd_state             <= RD_IDLE;
      DQ_O                 <= '0;
      DQ_OE_O              <= 1'b0;
      ECHO_TIMING_PAIR_O   <= ECHO_RST;
      ECHO_TIMING_PAIR_N_O <= ECHO_N_RST;
    end else if (CE_I) begin
      rd_pend              <= next_rd_pend;
      rd_burst             <= next_rd_burst;
      rd_hold              <= next_rd_hold;
      rd_state             <= next_rd_state;
      DQ_O                 <= next_dq;
      DQ_OE_O              <= next_oe;
      ECHO_TIMING_PAIR_O   <= next_echo;
      ECHO_TIMING_PAIR_N_O <= ~next_echo;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // Bus floats whenever no read word is out
  idle_bus_float_a: assert property (rd_state == RD_IDLE |-> !DQ_OE_O)
    else $error("data bus driven while idle");
  first_word_out_a: assert property (CE_I && pos_out && rd_pend |=>
    DQ_OE_O && DQ_O == $past(rd_burst.w0))
    else $error("first read word not driven");
  second_word_out_a: assert property (CE_I && neg_out && rd_state == RD_SECOND |=>
    DQ_OE_O && DQ_O == $past(rd_hold))
    else $error("second read word not driven");
  bus_release_a: assert property (CE_I && pos_out && !rd_pend |=> !DQ_OE_O)
    else $error("bus held after burst");
  // Echo pair follows whichever clock pair times the outputs
  echo_opposed_a: assert property (ECHO_TIMING_PAIR_O != ECHO_TIMING_PAIR_N_O)
    else $error("echo pair not complementary");
  echo_rise_a: assert property (CE_I && pos_out |=> ECHO_TIMING_PAIR_O)
    else $error("echo missed positive output edge");
  echo_fall_a: assert property (CE_I && neg_out && !pos_out |=> !ECHO_TIMING_PAIR_O)
    else $error("echo missed negative output edge");
  single_clock_a: assert property (CE_I && single && k_rise |=> ECHO_TIMING_PAIR_O)
    else $error("echo not on input clock in single clock mode");
  // Command side checks
  read_pend_a: assert property (CE_I && cmd_go && pins.rnw |=> rd_pend)
    else $error("read request not taken");
  load_high_a: assert property (CE_I && k_rise && pins.load_n && !rd_pend
    |=> !rd_pend && !wr_armed)
    else $error("command started with load high");
  write_arm_a: assert property (CE_I && cmd_go && !pins.rnw |=>
    wr_armed && wr_addr == $past(cmd_a0))
    else $error("write address not captured");
  write_second_a: assert property (CE_I && k_rise && wr_armed |=> wr_second ##0
    cur_addr == $past(wr_addr))
    else $error("second write half not armed");
  write_wrap_a: assert property (kn_rise && !k_rise && wr_second |->
    mem_we && mem_waddr[AW-1:1] == cur_addr[AW-1:1] && mem_waddr[0] != cur_addr[0])
    else $error("second word left its burst");
endmodule : ddr_burst2_sram_port
`default_nettype wire

// ==== testbench/sram_ctrl_model.sv ====
`default_nettype none
module sram_ctrl_model
  import ddr_port_pkg::*;
(
  // Clocks and mode
  input  wire logic              clk,
  input  wire logic              single,
  output logic                   k,
  output logic                   c,
  output logic                   c_n,
  // Read return
  input  wire logic              echo,
  input  wire logic              echo_n,
  input  wire logic              oe,
  input  wire logic [DATA_W-1:0] rd,
  // Command and write data
  output logic                   ld_n,
  output logic                   rnw,
  output logic [5:0]             addr,
  output logic [DATA_W-1:0]      dq,
  output logic [LANES-1:0]       mask_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] rq[$];
  logic [DATA_W-1:0] p0, p1;
  logic [LANES-1:0]  pm0, pm1;
  logic              c_lag;
  logic              wr;

  // Idle bus at start; a released data line carries inverted patterns
  initial begin
    k = 1'b0;
    c_lag = 1'b0;
    ld_n = 1'b1;
    rnw = 1'b0;
    addr = 6'h00;
    dq = 36'h0_0000_0000;
    mask_n = 4'hF;
    p0 = 36'hF_FFFF_FFFF;
    p1 = 36'h0_0000_0000;
    pm0 = 4'hF;
    pm1 = 4'hF;
  end

  // Input clock runs free, offset 1 ns so no edge lands on a system clock rise;
  // the output clock trails it by 30 ns
  initial begin
    #1;
    forever #62.5 k = ~k;
  end
  always @(k) c_lag <= #30 k;
  assign c   = single | c_lag;
  assign c_n = single | ~c_lag;

  // echo rises mark read words while the bus is driven
  always @(posedge echo or posedge echo_n) begin
    #1;
    if (oe === 1'b1) begin
      rq.push_back(rd);
    end
  end

  // command before a rise, its words and masks on the next rise and fall
  task automatic cycle(input logic go, input logic rd_c, input logic [5:0] a, input logic [DATA_W-1:0] w0,
                       input logic [DATA_W-1:0] w1, input logic [LANES-1:0] m0, input logic [LANES-1:0] m1);
    @(negedge k);
    repeat (3) @(posedge clk);
    #1;
    ld_n = ~go;
    rnw = rd_c;
    addr = a;
    dq = p0;
    mask_n = pm0;
    @(posedge k);
    repeat (3) @(posedge clk);
    #1;
    dq = p1;
    mask_n = pm1;
    wr = go & ~rd_c;
    p0 = wr ? w0 : ~p1;
    p1 = wr ? w1 : p1;
    pm0 = wr ? m0 : 4'h0;
    pm1 = wr ? m1 : 4'h0;
  endtask : cycle
endmodule : sram_ctrl_model
`default_nettype wire

// ==== testbench/tb_ddr_burst2_sram_port.sv ====
`default_nettype none
module tb_ddr_burst2_sram_port;
  timeunit 1ns;
  timeprecision 100ps;
  import ddr_port_pkg::*;

  typedef struct {
    logic              go;
    logic              rd;
    logic [5:0]        a;
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
    logic [LANES-1:0]  m0;
    logic [LANES-1:0]  m1;
  } row_t;

  logic              clk, rst, single, k, c, c_n, ld_n, rnw, oe, echo, echo_n;
  logic [5:0]        addr;
  logic [DATA_W-1:0] cdq, dq_o, dq_w;
  logic [LANES-1:0]  mask_n;
  logic [DATA_W-1:0] mem [64];
  logic [DATA_W-1:0] exq[$];
  int                n_mismatch, n_checks, cyc, n_echo, e0;
  row_t              rows [9];

  // Wire level of the shared data bus
  assign dq_w = oe ? dq_o : cdq;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  ddr_burst2_sram_port #(.AW(6)) u_ddr_burst2_sram_port (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .K_I(k), .K_N_I(~k), .C_I(c), .C_N_I(c_n),
    .LOAD_N_I(ld_n), .RNW_I(rnw), .WORD_ADDRESS_I(addr), .LANE_WRITE_MASK_N_I(mask_n),
    .NIBBLE_WRITE_MASK_N_I(mask_n[1:0]), .DQ_I(dq_w), .DQ_O(dq_o), .DQ_OE_O(oe),
    .ECHO_TIMING_PAIR_O(echo), .ECHO_TIMING_PAIR_N_O(echo_n));

  sram_ctrl_model u_sram_ctrl_model (
    .clk(clk), .single(single), .k(k), .c(c), .c_n(c_n), .echo(echo), .echo_n(echo_n), .oe(oe),
    .rd(dq_o), .ld_n(ld_n), .rnw(rnw), .addr(addr), .dq(cdq), .mask_n(mask_n));

  task automatic chk_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk_bit

  // unmasked lanes take the new bits
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
                                              input logic [LANES-1:0] m);
    merge = old;
    for (int n = 0; n < LANES; n++) begin
      if (!m[n]) merge[n*LANE_W +: LANE_W] = nw[n*LANE_W +: LANE_W];
    end
  endfunction : merge

  // second word goes to the other half of the same pair
  task automatic run_row(input row_t r);
    u_sram_ctrl_model.cycle(r.go, r.rd, r.a, r.w0, r.w1, r.m0, r.m1);
    if (r.go && r.rd) begin
      exq.push_back(mem[r.a]);
      exq.push_back(mem[r.a ^ 6'h01]);
    end else if (r.go) begin
      mem[r.a] = merge(mem[r.a], r.w0, r.m0);
      mem[r.a ^ 6'h01] = merge(mem[r.a ^ 6'h01], r.w1, r.m1);
    end
  endtask : run_row

  // Compare returned words against the model, then empty both queues
  task automatic drain;
    repeat (60) @(posedge clk);
    #1;
    chk_word("read count", DATA_W'(exq.size()), DATA_W'(u_sram_ctrl_model.rq.size()));
    while (exq.size() > 0 && u_sram_ctrl_model.rq.size() > 0) begin
      chk_word("read word", exq.pop_front(), u_sram_ctrl_model.rq.pop_front());
    end
    exq.delete();
    u_sram_ctrl_model.rq.delete();
  endtask : drain

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Echo pair stays complementary; a hang ends the run as a failure
  always @(posedge clk) begin
    if (!rst) chk_bit("echo pair", ~echo_n, echo);
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      $display("unexpected timeout: expected end, seen %0d cycles", cyc);
      print_verdict();
    end
  end
  always @(posedge echo) n_echo++;

  initial begin
    rst = 1'b1;
    single = 1'b0;
    rows = '{
      '{1'b1, 1'b0, 6'h04, 36'h1_1111_1111, 36'h2_2222_2222, 4'h0, 4'h0},
      '{1'b1, 1'b0, 6'h06, 36'h3_3333_3333, 36'h4_4444_4444, 4'h0, 4'h0},
      '{1'b1, 1'b0, 6'h07, 36'h5_5555_5555, 36'h6_6666_6666, 4'h5, 4'hA},
      '{1'b0, 1'b1, 6'h04, 36'h7_7777_7777, 36'h8_8888_8888, 4'h0, 4'h0},
      '{1'b1, 1'b1, 6'h04, 36'h0_0000_0000, 36'h0_0000_0000, 4'h0, 4'h0},
      '{1'b1, 1'b1, 6'h07, 36'h0_0000_0000, 36'h0_0000_0000, 4'h0, 4'h0},
      '{1'b1, 1'b1, 6'h06, 36'h0_0000_0000, 36'h0_0000_0000, 4'h0, 4'h0},
      '{1'b0, 1'b0, 6'h00, 36'h0_0000_0000, 36'h0_0000_0000, 4'h0, 4'h0},
      '{1'b0, 1'b0, 6'h00, 36'h0_0000_0000, 36'h0_0000_0000, 4'h0, 4'h0}};
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    // writes, an ignored read, back-to-back reads
    foreach (rows[i]) run_row(rows[i]);
    drain();
    chk_bit("bus enable after reads", 1'b0, oe);
    e0 = n_echo;
    repeat (50) @(posedge clk);
    chk_word("echo rises while idle", 36'h0_0000_0002, DATA_W'(n_echo - e0));
    $display("normal clock rows done");
    // single-clock read of the upper word wraps to the lower one
    single = 1'b1;
    run_row(rows[7]);
    run_row(rows[5]);
    run_row(rows[7]);
    run_row(rows[7]);
    drain();
    $display("single clock read done");
    // Reset in mid-run releases the bus and parks the echo pair
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_bit("bus enable in reset", 1'b0, oe);
    chk_bit("echo in reset", ECHO_RST, echo);
    chk_bit("echo_n in reset", ECHO_N_RST, echo_n);
    $display("reset test done");
    print_verdict();
  end
endmodule : tb_ddr_burst2_sram_port
`default_nettype wire
